// *** rtl/mpf_motor_protection.sv ***
// module: thermal relay, heatsink trip, fault record and fault terminals
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module mpf_motor_protection #(
  parameter int TICK_CYCLES = mpf_pkg::TICK_CYCLES
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire mpf_pkg::mpf_pins_t pins,
  output logic                   drive_enable,
  output logic [1:0]             thermal_trip_ind,
  output logic                   overheat_warning,
  output logic                   uv_warning,
  output logic [3:0]             fault_terminal,
  output logic                   irq,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // pins come from other logic domains: two flops before use; a word is
  // taken only once two samples agree, so bit skew never forms a false
  // code or temperature; a pin word that never settles is never taken
  mpf_pkg::mpf_pins_t pin_meta_reg;
  mpf_pkg::mpf_pins_t pin_sync_reg;
  mpf_pkg::mpf_pins_t pin_last_reg;
  mpf_pkg::mpf_pins_t pin_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      pin_last_reg <= '0;
      pin_reg      <= '0;
    end else begin
      pin_meta_reg <= pins;
      pin_sync_reg <= pin_meta_reg;
      pin_last_reg <= pin_sync_reg;
      if (pin_sync_reg == pin_last_reg)
        pin_reg <= pin_sync_reg;
    end
  end

  // ---------------- register bus ----------------
  logic [15:0]      mask_reg [4];
  logic [12:0]      therm_reg [2];
  logic [11:0]      warn_lvl_reg;
  logic [mpf_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [mpf_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [mpf_pkg::IRQ_W-1:0] irq_event;
  logic [7:0]       aw_addr_reg;
  logic [31:0]      w_data_reg;
  logic [3:0]       w_strb_reg;
  logic             wr_fire;
  logic             sw_fault_reset;
  logic             fault_active_reg;
  logic [7:0]       fault_code_reg;
  logic [7:0]       record_reg [mpf_pkg::REC_DEPTH];

  // address and data may arrive in either order; ready drops once held
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= mpf_pkg::RESP_OKAY;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped(aw_addr_reg) ? mpf_pkg::RESP_OKAY
                                               : mpf_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  function automatic logic wr_mapped(input logic [7:0] a);
    wr_mapped = (a <= mpf_pkg::ADDR_CTRL) && (a[1:0] == 2'b00) ||
                a == mpf_pkg::ADDR_IRQ_STAT || a == mpf_pkg::ADDR_IRQ_MASK;
  endfunction : wr_mapped

  // low halfword must be written whole for the wide fields
  logic lo_whole;
  assign lo_whole = &w_strb_reg[1:0];

  // fault category masks, four of them
  generate
    for (genvar m = 0; m < 4; m++) begin : g_mask
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          mask_reg[m] <= mpf_pkg::MASK_RESET;
        end else if (wr_fire && lo_whole &&
                     aw_addr_reg == mpf_pkg::ADDR_MASK_1 + 8'(4 * m)) begin
          mask_reg[m] <= w_data_reg[15:0];
        end
      end
    end
  endgenerate

  // action times clamp to 30.0 .. 600.0 s
  generate
    for (genvar t = 0; t < 2; t++) begin : g_therm
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          therm_reg[t] <= mpf_pkg::THERM_RESET;
        end else if (wr_fire && lo_whole &&
                     aw_addr_reg == mpf_pkg::ADDR_THERM_1 + 8'(4 * t)) begin
          if (w_data_reg[15:0] < 16'(mpf_pkg::THERM_MIN))
            therm_reg[t] <= mpf_pkg::THERM_MIN;
          else if (w_data_reg[15:0] > 16'(mpf_pkg::THERM_MAX))
            therm_reg[t] <= mpf_pkg::THERM_MAX;
          else
            therm_reg[t] <= w_data_reg[12:0];
        end
      end
    end
  endgenerate

  // warning level clamps to 110.0 degrees
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      warn_lvl_reg <= mpf_pkg::WARN_RESET;
    end else if (wr_fire && lo_whole &&
                 aw_addr_reg == mpf_pkg::ADDR_WARN_LVL) begin
      if (w_data_reg[15:0] > 16'(mpf_pkg::WARN_MAX))
        warn_lvl_reg <= mpf_pkg::WARN_MAX;
      else
        warn_lvl_reg <= w_data_reg[11:0];
    end
  end

  assign sw_fault_reset = wr_fire && w_strb_reg[0] &&
                          aw_addr_reg == mpf_pkg::ADDR_CTRL &&
                          w_data_reg[mpf_pkg::CTRL_FAULT_RESET];

  // sticky status: a new event beats a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
    end else begin
      if (wr_fire && w_strb_reg[0] &&
          aw_addr_reg == mpf_pkg::ADDR_IRQ_STAT)
        irq_stat_reg <= (irq_stat_reg &
                         ~w_data_reg[mpf_pkg::IRQ_W-1:0]) | irq_event;
      else
        irq_stat_reg <= irq_stat_reg | irq_event;
      if (wr_fire && w_strb_reg[0] &&
          aw_addr_reg == mpf_pkg::ADDR_IRQ_MASK)
        irq_mask_reg <= w_data_reg[mpf_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_reg & irq_mask_reg);
  end

  // read side: one outstanding read, answer one cycle after address
  logic [31:0] rd_value;
  logic        rd_ok;

  always_comb begin
    rd_value = 32'h0000_0000;
    rd_ok    = 1'b1;
    unique case (s_axi_araddr)
      mpf_pkg::ADDR_MASK_1:   rd_value = {16'h0000, mask_reg[0]};
      mpf_pkg::ADDR_MASK_2:   rd_value = {16'h0000, mask_reg[1]};
      mpf_pkg::ADDR_MASK_3:   rd_value = {16'h0000, mask_reg[2]};
      mpf_pkg::ADDR_MASK_4:   rd_value = {16'h0000, mask_reg[3]};
      mpf_pkg::ADDR_THERM_1:  rd_value = {19'h0, therm_reg[0]};
      mpf_pkg::ADDR_THERM_2:  rd_value = {19'h0, therm_reg[1]};
      mpf_pkg::ADDR_WARN_LVL: rd_value = {20'h0, warn_lvl_reg};
      mpf_pkg::ADDR_CTRL:     rd_value = 32'h0000_0000;
      mpf_pkg::ADDR_STATUS: begin
        rd_value[mpf_pkg::ST_FAULT_ACTIVE] = fault_active_reg;
        rd_value[mpf_pkg::ST_CODE_LSB +: 8] = fault_code_reg;
      end
      mpf_pkg::ADDR_IRQ_STAT: rd_value = 32'(irq_stat_reg);
      mpf_pkg::ADDR_IRQ_MASK: rd_value = 32'(irq_mask_reg);
      default: begin
        if (s_axi_araddr >= mpf_pkg::ADDR_REC_0 &&
            s_axi_araddr <= mpf_pkg::ADDR_REC_5 &&
            s_axi_araddr[1:0] == 2'b00)
          rd_value = 32'(record_reg[3'(
                       (s_axi_araddr - mpf_pkg::ADDR_REC_0) >> 2)]);
        else
          rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= mpf_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_value;
      s_axi_rresp   <= rd_ok ? mpf_pkg::RESP_OKAY : mpf_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------- thermal relay ----------------
  logic        fault_clear;
  logic [13:0] tick_cnt_reg;
  logic        tick;
  logic [31:0] therm_acc_reg [2];
  logic [1:0]  therm_trip;

  assign fault_clear = sw_fault_reset || pin_reg.fault_reset;
  assign tick = tick_cnt_reg == 14'(TICK_CYCLES - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn || tick)
      tick_cnt_reg <= 14'h0000;
    else
      tick_cnt_reg <= tick_cnt_reg + 14'h0001;
  end

  // adding the current itself each ms: threshold is action time at 150 %,
  // so double current trips in half the time; no cooling while below
  generate
    for (genvar k = 0; k < 2; k++) begin : g_relay
      logic [31:0] limit;
      assign limit = 32'(therm_reg[k]) * mpf_pkg::MS_PER_TENTH *
                     32'(mpf_pkg::CURRENT_LIMIT);
      assign therm_trip[k] = therm_acc_reg[k] >= limit;
      always_ff @(posedge aclk) begin
        if (!aresetn || fault_clear) begin
          therm_acc_reg[k] <= 32'h0000_0000;
        end else if (tick && pin_reg.motor_two == 1'(k) &&
                     pin_reg.current_pct > mpf_pkg::CURRENT_LIMIT &&
                     !therm_trip[k]) begin
          therm_acc_reg[k] <= therm_acc_reg[k] +
                              32'(pin_reg.current_pct);
        end
      end
    end
  endgenerate

  // ---------------- heatsink temperature ----------------
  logic unreduced;
  logic temp_trip;
  logic warn_now;

  assign unreduced = warn_lvl_reg >= mpf_pkg::WARN_RESET;

  always_comb begin
    if ((pin_reg.heavy_duty || pin_reg.sensorless) && unreduced) begin
      warn_now  = 1'b0;
      temp_trip = pin_reg.temp_dc >= mpf_pkg::TEMP_TRIP_LOW;
    end else begin
      warn_now  = pin_reg.temp_dc >= warn_lvl_reg;
      temp_trip = pin_reg.temp_dc >= mpf_pkg::TEMP_TRIP_HI;
    end
  end

  // ---------------- fault capture ----------------
  logic [7:0] new_code;
  logic       uv_running;

  assign uv_running = pin_reg.undervoltage &&
                      pin_reg.phase != mpf_pkg::MPF_STOPPED;

  always_comb begin
    new_code = mpf_pkg::CODE_NONE;
    if (pin_reg.ext_valid && pin_reg.ext_code != mpf_pkg::CODE_NONE)
      new_code = pin_reg.ext_code;
    else if (therm_trip[0])
      new_code = mpf_pkg::CODE_THERM_ONE;
    else if (therm_trip[1])
      new_code = mpf_pkg::CODE_THERM_TWO;
    else if (pin_reg.sensor_open)
      new_code = mpf_pkg::CODE_SENSOR_OPEN;
    else if (temp_trip)
      new_code = mpf_pkg::CODE_SW_OVERTEMP;
    else if (uv_running) begin
      unique case (pin_reg.phase)
        mpf_pkg::MPF_ACCEL: new_code = mpf_pkg::CODE_UV_ACCEL;
        mpf_pkg::MPF_DECEL: new_code = mpf_pkg::CODE_UV_DECEL;
        default:            new_code = mpf_pkg::CODE_UV_CONST;
      endcase
    end
  end

  logic record_new;
  logic backup_new;

  // only the first fault of a stop is captured; reset re-arms
  assign record_new = !fault_active_reg && new_code != mpf_pkg::CODE_NONE;
  assign backup_new = !fault_active_reg && pin_reg.backup_run;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_active_reg <= 1'b0;
      fault_code_reg   <= mpf_pkg::CODE_NONE;
    end else if (backup_new) begin
      fault_active_reg <= 1'b1;
      fault_code_reg   <= mpf_pkg::CODE_DECEL_BACKUP;
    end else if (record_new) begin
      fault_active_reg <= 1'b1;
      fault_code_reg   <= new_code;
    end else if (fault_clear) begin
      fault_active_reg <= 1'b0;
      fault_code_reg   <= mpf_pkg::CODE_NONE;
    end
  end

  // newest entry at index 0; older ones shift down; a backup run overwrites every entry with its code
  generate
    for (genvar r = 0; r < mpf_pkg::REC_DEPTH; r++) begin : g_rec
      always_ff @(posedge aclk) begin
        if (!aresetn)
          record_reg[r] <= mpf_pkg::CODE_NONE;
        else if (backup_new)
          record_reg[r] <= mpf_pkg::CODE_DECEL_BACKUP;
        else if (record_new) begin
          if (r == 0)
            record_reg[r] <= new_code;
          else
            record_reg[r] <= record_reg[r - 1];
        end
      end
    end
  endgenerate

  // ---------------- category map ----------------
  function automatic logic [6:0] fault_category(input logic [7:0] c);
    fault_category = 7'h00;
    unique case (c)
      8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h4F, 8'h50, 8'h52:
        fault_category[mpf_pkg::CAT_CURRENT] = 1'b1;
      8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F:
        fault_category[mpf_pkg::CAT_VOLTAGE] = 1'b1;
      8'h10, 8'h15, 8'h18, 8'h1A, 8'h1B, 8'h57:
        fault_category[mpf_pkg::CAT_OVERLOAD] = 1'b1;
      8'h1F, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h28, 8'h34,
      8'h4C, 8'h4D, 8'h4E:
        fault_category[mpf_pkg::CAT_SYSTEM] = 1'b1;
      8'h29, 8'h2A, 8'h2B, 8'h2D, 8'h30, 8'h59:
        fault_category[mpf_pkg::CAT_FEEDBACK] = 1'b1;
      8'h31, 8'h32, 8'h33, 8'h3D:
        fault_category[mpf_pkg::CAT_EXTERNAL] = 1'b1;
      8'h39, 8'h3A, 8'h65, 8'h66, 8'h68, 8'h69:
        fault_category[mpf_pkg::CAT_COMM] = 1'b1;
      default: fault_category = 7'h00;
    endcase
  endfunction : fault_category

  logic [6:0] active_cat;
  assign active_cat = fault_category(fault_code_reg);

  // terminal follows the held fault and drops on reset
  generate
    for (genvar o = 0; o < 4; o++) begin : g_term
      always_ff @(posedge aclk) begin
        if (!aresetn)
          fault_terminal[o] <= 1'b0;
        else
          fault_terminal[o] <= fault_active_reg &&
                               |(active_cat & mask_reg[o][6:0]);
      end
    end
  endgenerate

  // ---------------- outputs and events ----------------
  logic warn_prev_reg;
  logic uv_prev_reg;
  logic uv_stop;

  assign uv_stop = pin_reg.undervoltage &&
                   pin_reg.phase == mpf_pkg::MPF_STOPPED;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_enable     <= 1'b0;
      thermal_trip_ind <= 2'b00;
      overheat_warning <= 1'b0;
      uv_warning       <= 1'b0;
      warn_prev_reg    <= 1'b0;
      uv_prev_reg      <= 1'b0;
    end else begin
      // drive is cut, motor coasts, for every held fault
      drive_enable     <= !fault_active_reg && !record_new &&
                          !backup_new;
      if (fault_clear && !record_new)
        thermal_trip_ind <= 2'b00;
      else if (record_new && new_code == mpf_pkg::CODE_THERM_ONE)
        thermal_trip_ind[0] <= 1'b1;
      else if (record_new && new_code == mpf_pkg::CODE_THERM_TWO)
        thermal_trip_ind[1] <= 1'b1;
      overheat_warning <= warn_now;
      uv_warning       <= uv_stop;
      warn_prev_reg    <= warn_now;
      uv_prev_reg      <= uv_stop;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[mpf_pkg::IRQ_FAULT]   = record_new || backup_new;
    irq_event[mpf_pkg::IRQ_THERMAL] = record_new &&
      (new_code == mpf_pkg::CODE_THERM_ONE ||
       new_code == mpf_pkg::CODE_THERM_TWO);
    irq_event[mpf_pkg::IRQ_WARN]    = warn_now && !warn_prev_reg;
    irq_event[mpf_pkg::IRQ_UV_WARN] = uv_stop && !uv_prev_reg;
    irq_event[mpf_pkg::IRQ_BACKUP]  = backup_new;
  end

endmodule : mpf_motor_protection

`default_nettype wire

// *** rtl/mpf_pkg.sv ***
// package: constants and carriers of the motor protection fault logger
package mpf_pkg;
  // bus map
  localparam logic [7:0] ADDR_MASK_1   = 8'h00;
  localparam logic [7:0] ADDR_MASK_2   = 8'h04;
  localparam logic [7:0] ADDR_MASK_3   = 8'h08;
  localparam logic [7:0] ADDR_MASK_4   = 8'h0C;
  localparam logic [7:0] ADDR_THERM_1  = 8'h10;
  localparam logic [7:0] ADDR_THERM_2  = 8'h14;
  localparam logic [7:0] ADDR_WARN_LVL = 8'h18;
  localparam logic [7:0] ADDR_CTRL     = 8'h1C;
  localparam logic [7:0] ADDR_STATUS   = 8'h20;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
  localparam logic [7:0] ADDR_REC_0    = 8'h30;
  localparam logic [7:0] ADDR_REC_5    = 8'h44;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  // resets and limits, tenths of a second / tenths of a degree, current limit in percent
  localparam logic [15:0] MASK_RESET    = 16'h0000;
  localparam logic [12:0] THERM_RESET   = 13'h0258;
  localparam logic [12:0] THERM_MIN     = 13'h012C;
  localparam logic [12:0] THERM_MAX     = 13'h1770;
  localparam logic [11:0] WARN_RESET    = 12'h41A;
  localparam logic [11:0] WARN_MAX      = 12'h44C;
  localparam logic [11:0] TEMP_TRIP_LOW = 12'h3E8;
  localparam logic [11:0] TEMP_TRIP_HI  = 12'h44C;
  localparam logic [15:0] CURRENT_LIMIT = 16'h0096;
  localparam logic [31:0] MS_PER_TENTH  = 32'h0000_0064;
  // field positions
  localparam int CTRL_FAULT_RESET = 0;
  localparam int ST_FAULT_ACTIVE  = 0;
  localparam int ST_CODE_LSB      = 8;
  localparam int IRQ_W            = 5;
  localparam int IRQ_FAULT        = 0;
  localparam int IRQ_THERMAL      = 1;
  localparam int IRQ_WARN         = 2;
  localparam int IRQ_UV_WARN      = 3;
  localparam int IRQ_BACKUP       = 4;
  // category bits within a fault mask
  localparam int CAT_CURRENT  = 0;
  localparam int CAT_VOLTAGE  = 1;
  localparam int CAT_OVERLOAD = 2;
  localparam int CAT_SYSTEM   = 3;
  localparam int CAT_FEEDBACK = 4;
  localparam int CAT_EXTERNAL = 5;
  localparam int CAT_COMM     = 6;
  // fault codes
  localparam logic [7:0] CODE_NONE          = 8'h00;
  localparam logic [7:0] CODE_UV_ACCEL      = 8'h0B;
  localparam logic [7:0] CODE_UV_DECEL      = 8'h0C;
  localparam logic [7:0] CODE_UV_CONST      = 8'h0D;
  localparam logic [7:0] CODE_SW_OVERTEMP   = 8'h10;
  localparam logic [7:0] CODE_SENSOR_OPEN   = 8'h12;
  localparam logic [7:0] CODE_THERM_ONE     = 8'h16;
  localparam logic [7:0] CODE_THERM_TWO     = 8'h17;
  localparam logic [7:0] CODE_DECEL_BACKUP  = 8'h3E;
  localparam int REC_DEPTH = 6;
  // timing: one accumulation tick per millisecond
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MPF_STOPPED, MPF_ACCEL, MPF_DECEL, MPF_CONST
  } mpf_phase_t;

  typedef struct packed {
    logic [15:0] current_pct;
    logic [11:0] temp_dc;
    mpf_phase_t  phase;
    logic        motor_two;
    logic        heavy_duty;
    logic        sensorless;
    logic        undervoltage;
    logic        sensor_open;
    logic        backup_run;
    logic        ext_valid;
    logic [7:0]  ext_code;
    logic        fault_reset;
  } mpf_pins_t;
endpackage : mpf_pkg

// *** tb/mpf_motor_protection_assertions.sv ***
// checker: port assertions of the motor protection block
`timescale 1ns/1ns
`default_nettype none
module mpf_motor_protection_assertions (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire mpf_pkg::mpf_pins_t pins,
  input wire logic               drive_enable,
  input wire logic [1:0]         thermal_trip_ind,
  input wire logic [3:0]         fault_terminal,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  chk_b_busy: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("ready in response");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read unanswered");
  chk_trip_coast: assert property (|thermal_trip_ind ##1
    |thermal_trip_ind |-> !drive_enable) else $error("trip kept drive");
  chk_term_coast: assert property (|fault_terminal |->
    !drive_enable) else $error("terminal without fault");
  chk_hot_trip: assert property ((pins.temp_dc >=
    mpf_pkg::TEMP_TRIP_HI && !pins.fault_reset) [*6] |-> !drive_enable)
    else $error("no heat trip");
  chk_backup_coast: assert property ((pins.backup_run &&
    !pins.fault_reset) [*6] |-> !drive_enable) else $error("backup ran");
endmodule : mpf_motor_protection_assertions
bind mpf_motor_protection mpf_motor_protection_assertions mpf_chk_i (
  .aclk, .aresetn, .pins, .drive_enable, .thermal_trip_ind, .fault_terminal,
  .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// *** tb/mpf_terminal_sink.sv ***
// partner: output terminal sink remembering which terminals fired
`timescale 1ns/1ns
`default_nettype none
module mpf_terminal_sink (
  input  wire logic       aclk,
  input  wire logic       clr,
  input  wire logic [3:0] terminal,
  output logic      [3:0] seen
);
  // sticky so a one-cycle glitch on a wrong terminal is not missed
  always_ff @(posedge aclk) begin
    if (clr) seen <= 4'h0;
    else seen <= seen | terminal;
  end
endmodule : mpf_terminal_sink
`default_nettype wire

// *** tb/tb_mpf_motor_protection.sv ***
// bench: registers, fault record, terminals and interrupt of the block
`timescale 1ns/1ns
`default_nettype none
module tb_mpf_motor_protection;
  logic        aclk = 1'b0, aresetn = 1'b0, clr = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, drive_enable, overheat_warning, uv_warning, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, thermal_trip_ind, resp;
  logic [3:0]  fault_terminal, seen;
  logic [15:0] m [4];
  int          failures = 0, checks = 0, cyc = 0, seed = 32'h44BD211D;
  mpf_pkg::mpf_pins_t pins = '0;
  always #50 aclk = ~aclk;
  mpf_motor_protection #(.TICK_CYCLES(10)) mpf_motor_protection_i (
    .aclk, .aresetn, .pins, .drive_enable, .thermal_trip_ind,
    .overheat_warning, .uv_warning, .fault_terminal, .irq, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  mpf_terminal_sink mpf_terminal_sink_i (.aclk, .clr,
    .terminal(fault_terminal), .seen);
  task automatic chk(input string n, input logic [31:0] e, s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  function automatic int cat(input int c);
    if (c inside {1, 2, 3, 4, 6}) return 0;
    if (c inside {[7:13]}) return 1;
    if (c inside {16, 21}) return 2;
    if (c == 58) return 6;
    return -1;
  endfunction : cat
  task automatic run(input int c);
    mpf_pkg::mpf_pins_t p;
    logic [3:0] t;
    int e;
    int k;
    int n;
    p = '0;
    p.temp_dc = 12'h0FA;
    e = (c == 116) ? 16 : c;
    case (c)
      11, 12, 13: begin
        p.undervoltage = 1'b1;
        p.phase = mpf_pkg::mpf_phase_t'(c - 10);
      end
      116: begin
        p.heavy_duty = 1'b1;
        p.temp_dc = mpf_pkg::TEMP_TRIP_LOW;
      end
      16: p.temp_dc = mpf_pkg::TEMP_TRIP_HI;
      18: p.sensor_open = 1'b1;
      62: p.backup_run = 1'b1;
      22, 23: begin
        // lower current on motor two: the trip must take longer
        p.current_pct = (c == 22) ? 16'hFFFF : 16'h7FFF;
        p.motor_two = (c == 23);
        // ticks to reach action time x 100 ms x 150 %
        n = (mpf_pkg::THERM_MIN * 15000 + p.current_pct - 1) / p.current_pct;
      end
      default: begin
        p.ext_valid = 1'b1;
        p.ext_code = 8'(c);
      end
    endcase
    @(posedge aclk);
    pins <= p;
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    for (k = 0; k < 3000 && drive_enable !== 1'b0; k++) @(posedge aclk);
    // ten cycles a tick, plus pin sync and tick phase
    if (c > 21 && c < 24)
      chk("trip", 1, 32'(k > 10*n-5 && k < 10*n+6));
    repeat (2) @(posedge aclk);
    rd(mpf_pkg::ADDR_STATUS);
    chk("code", e, rdat[15:8]);
    rd(mpf_pkg::ADDR_REC_0);
    chk("record", e, rdat);
    rd(mpf_pkg::ADDR_REC_5);
    if (c == 62) chk("record 5", 62, rdat);
    if (c > 21 && c < 24) chk("ind", c - 21, thermal_trip_ind);
    if (c == 116) chk("warning", 0, overheat_warning);
    if (c == 16) chk("warning", 1, overheat_warning);
    t = 4'h0;
    if (cat(e) >= 0)
      for (k = 0; k < 4; k++) t[k] = m[k][cat(e)];
    chk("terminals", t, seen);
    p = '0;
    p.temp_dc = 12'h0FA;
    pins <= p;
    // let the quiet pins pass the sync before clearing, or the fault returns
    repeat (4) @(posedge aclk);
    wr(mpf_pkg::ADDR_CTRL, 32'h1);
    repeat (6) @(posedge aclk);
    chk("drive", 1, drive_enable);
    chk("terminals", 0, fault_terminal);
  endtask : run
  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    mpf_pkg::mpf_pins_t p;
    int codes[$];
    codes = '{1, 2, 3, 4, 6, 7, 8, 9, 10, 21, 58, 11, 12, 13, 116, 16, 18,
              62, 22, 23};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(mpf_pkg::ADDR_WARN_LVL);
    chk("warn", mpf_pkg::WARN_RESET, rdat);
    wr(mpf_pkg::ADDR_WARN_LVL, 32'hFFF);
    rd(mpf_pkg::ADDR_WARN_LVL);
    chk("warn", mpf_pkg::WARN_MAX, rdat);
    wr(mpf_pkg::ADDR_THERM_1, 32'h0);
    wr(mpf_pkg::ADDR_THERM_2, 32'h0);
    rd(mpf_pkg::ADDR_THERM_2);
    chk("action", mpf_pkg::THERM_MIN, rdat);
    foreach (m[i]) begin
      rd(mpf_pkg::ADDR_MASK_1 + 8'(4 * i));
      chk("mask", 0, rdat);
      m[i] = 16'($random(seed)) | ((i == 0) ? 16'h0047 : 16'h0000);
      wr(mpf_pkg::ADDR_MASK_1 + 8'(4 * i), {16'h0000, m[i]});
      rd(mpf_pkg::ADDR_MASK_1 + 8'(4 * i));
      chk("mask", m[i], rdat);
    end
    wr(8'h2C, 32'h1);
    chk("bresp", mpf_pkg::RESP_SLVERR, resp);
    rd(8'h2C);
    chk("rresp", mpf_pkg::RESP_SLVERR, resp);
    $display("test registers done");
    foreach (codes[k]) run(codes[k]);
    $display("test faults done");
    p = '0;
    p.temp_dc = 12'h0FA;
    p.undervoltage = 1'b1;
    pins <= p;
    repeat (8) @(posedge aclk);
    chk("uv warning", 1, uv_warning);
    rd(mpf_pkg::ADDR_STATUS);
    chk("code", 0, rdat[15:8]);
    chk("irq", 0, irq);
    wr(mpf_pkg::ADDR_IRQ_MASK, 32'h1F);
    repeat (3) @(posedge aclk);
    chk("irq", 1, irq);
    pins <= '0;
    wr(mpf_pkg::ADDR_IRQ_STAT, 32'h1F);
    repeat (3) @(posedge aclk);
    chk("irq", 0, irq);
    $display("test status done");
    final_report();
  end
endmodule : tb_mpf_motor_protection
`default_nettype wire
